// File: flash_link_pkg.sv
package flash_link_pkg;

    // Clock and timing figures
    localparam int unsigned CLK_MHZ                 = 100;
    localparam int unsigned POWERUP_WAIT_MS         = 20;
    localparam int unsigned POWERUP_WAIT_CYC        = POWERUP_WAIT_MS * 1000 * CLK_MHZ;
    localparam int unsigned SCK_MAX_MHZ_STD         = 20;
    localparam int unsigned SCK_MAX_MHZ_LOW         = 15;
    localparam int unsigned SCK_HALF_CYC            = (CLK_MHZ + 2 * SCK_MAX_MHZ_STD - 1)
                                                      / (2 * SCK_MAX_MHZ_STD) + 1;
    localparam int unsigned CS_HIGH_NS              = 250;
    localparam int unsigned CS_HIGH_CYC             = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SELECT_TO_BUSY_DELAY_NS = 200;
    localparam int unsigned SELECT_TO_BUSY_CYC      = SELECT_TO_BUSY_DELAY_NS * CLK_MHZ / 1000;
    localparam int unsigned TRANSFER_COMPARE_TIME_US = 250;
    localparam int unsigned TRANSFER_COMPARE_CYC    = TRANSFER_COMPARE_TIME_US * CLK_MHZ;
    localparam int unsigned ERASE_PROGRAM_TIME_MS   = 20;
    localparam int unsigned ERASE_PROGRAM_CYC       = ERASE_PROGRAM_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned PROGRAM_TIME_MS         = 14;
    localparam int unsigned PROGRAM_CYC             = PROGRAM_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned PAGE_ERASE_TIME_MS      = 8;
    localparam int unsigned PAGE_ERASE_CYC          = PAGE_ERASE_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned BLOCK_ERASE_TIME_MS     = 12;
    localparam int unsigned BLOCK_ERASE_CYC         = BLOCK_ERASE_TIME_MS * 1000 * CLK_MHZ;

    // Framing
    localparam int unsigned BITS_PER_BYTE           = 8;
    localparam logic [7:0]  RESERVED_ADDR_VALUE     = 8'h00;
    localparam logic [7:0]  BYTE_RESET_VALUE        = 8'h00;

    // Kinds of internal operation started on select release
    typedef enum logic [2:0] {
        OP_NONE,
        OP_XFER_COMPARE,
        OP_ERASE_PROGRAM,
        OP_PROGRAM,
        OP_PAGE_ERASE,
        OP_BLOCK_ERASE
    } op_kind_t;

endpackage : flash_link_pkg

// File: flash_link_if.sv
`timescale 1ns/1ps
interface flash_link_if;
    logic select_n;
    logic sclk;
    logic mosi;
    logic miso_o;
    logic miso_oe;
    logic ready;
    logic reset_n;

    // Resolved serial output wire as seen by the host
    logic miso;
    assign miso = miso_oe ? miso_o : 1'b1;

    modport flash
    (
        input  select_n,
        input  sclk,
        input  mosi,
        input  reset_n,
        output miso_o,
        output miso_oe,
        output ready
    );

    modport host
    (
        output select_n,
        output sclk,
        output mosi,
        output reset_n,
        input  miso,
        input  ready
    );
endinterface : flash_link_if

// File: flash_end.sv
`timescale 1ns/1ps
module flash_end
#(
    parameter int unsigned XFER_CYC        = flash_link_pkg::TRANSFER_COMPARE_CYC,
    parameter int unsigned ERASE_PROG_CYC  = flash_link_pkg::ERASE_PROGRAM_CYC,
    parameter int unsigned PROG_CYC        = flash_link_pkg::PROGRAM_CYC,
    parameter int unsigned PAGE_ERASE_CYCS = flash_link_pkg::PAGE_ERASE_CYC,
    parameter int unsigned BLOCK_ERASE_CYCS = flash_link_pkg::BLOCK_ERASE_CYC
)
(
    // Clock and reset
    input  wire logic                     clk_sys,
    input  wire logic                     srst,
    // Link
    flash_link_if.flash                   link,
    // User side: received bytes
    output logic [7:0]                    rx_byte,
    output logic                          rx_valid,
    output logic                          rx_first,
    // User side: byte to shift out, taken at each byte boundary
    input  wire logic [7:0]               tx_byte,
    // User side: internal operation to start on select release
    input  wire flash_link_pkg::op_kind_t op_kind,
    output logic                          op_done,
    output logic                          frame_active
);
    import flash_link_pkg::*;

    localparam int unsigned CNT_W = 32;

    logic [2:0]       sel_sync_r;
    logic [2:0]       clk_sync_r;
    logic [2:0]       mosi_sync_r;
    logic [2:0]       rst_sync_r;
    logic             sel_n_r;
    logic             sclk_r;
    logic             rst_n_r;
    logic [2:0]       bit_cnt_r;
    logic [7:0]       shift_r;
    logic [7:0]       tx_r;
    logic             first_r;
    logic [7:0]       rx_byte_r;
    logic             rx_valid_r;
    logic             rx_first_r;
    logic             miso_r;
    logic             miso_oe_r;
    logic             ready_r;
    logic             op_done_r;
    logic             active_r;
    logic [CNT_W-1:0] busy_cnt_r;
    logic [CNT_W-1:0] busy_cnt_nxt;

    wire sel_agree   = sel_sync_r[2] == sel_sync_r[1];
    wire clk_agree   = clk_sync_r[2] == clk_sync_r[1];
    wire rst_agree   = rst_sync_r[2] == rst_sync_r[1];
    wire sel_n_new   = sel_agree ? sel_sync_r[1] : sel_n_r;
    wire sclk_new    = clk_agree ? clk_sync_r[1] : sclk_r;
    wire rst_n_new   = rst_agree ? rst_sync_r[1] : rst_n_r;
    wire in_reset    = srst || !rst_n_new;
    wire sel_fall    = selected && !active_r;                      // First selected cycle
    wire sel_rise    = !sel_n_r && sel_n_new;
    wire selected    = !sel_n_r && !sel_n_new;
    wire sclk_rise   = selected && !sclk_r && sclk_new;
    wire sclk_fall   = selected && sclk_r && !sclk_new;
    wire byte_done   = sclk_rise && bit_cnt_r == 3'(BITS_PER_BYTE - 1);
    wire [7:0] rx_full = {shift_r[6:0], mosi_sync_r[2]};
    wire op_start    = sel_rise && ready_r && op_kind != OP_NONE;

    always_comb
    begin
        unique case (op_kind)
            OP_XFER_COMPARE:  busy_cnt_nxt = CNT_W'(XFER_CYC);
            OP_ERASE_PROGRAM: busy_cnt_nxt = CNT_W'(ERASE_PROG_CYC);
            OP_PROGRAM:       busy_cnt_nxt = CNT_W'(PROG_CYC);
            OP_PAGE_ERASE:    busy_cnt_nxt = CNT_W'(PAGE_ERASE_CYCS);
            OP_BLOCK_ERASE:   busy_cnt_nxt = CNT_W'(BLOCK_ERASE_CYCS);
            default:          busy_cnt_nxt = '0;
        endcase
    end

    // Three-stage input synchronisers
    always_ff @(posedge clk_sys)
    begin
        sel_sync_r  <= {sel_sync_r[1:0], link.select_n};
        clk_sync_r  <= {clk_sync_r[1:0], link.sclk};
        mosi_sync_r <= {mosi_sync_r[1:0], link.mosi};
        rst_sync_r  <= {rst_sync_r[1:0], link.reset_n};
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sel_n_r <= 1'b1;
            sclk_r  <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            sel_n_r <= sel_n_new;
            sclk_r  <= sclk_new;
            rst_n_r <= rst_n_new;
        end
    end

    // Byte framing and shifting
    always_ff @(posedge clk_sys)
    begin
        if (in_reset || !selected)
        begin
            bit_cnt_r <= '0;
            shift_r   <= BYTE_RESET_VALUE;
            first_r   <= 1'b1;
        end
        else if (sclk_rise)
        begin
            bit_cnt_r <= bit_cnt_r + 3'd1;
            shift_r   <= rx_full;
            if (byte_done)
                first_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
        begin
            rx_byte_r  <= BYTE_RESET_VALUE;
            rx_valid_r <= 1'b0;
            rx_first_r <= 1'b0;
        end
        else
        begin
            rx_valid_r <= byte_done;
            if (byte_done)
            begin
                rx_byte_r  <= rx_full;
                rx_first_r <= first_r;
            end
        end
    end

    // Serial output: msb first, first bit driven on select, then changes on falling clock
    always_ff @(posedge clk_sys)
    begin
        if (in_reset || !selected)
        begin
            tx_r      <= BYTE_RESET_VALUE;
            miso_r    <= 1'b0;
            miso_oe_r <= 1'b0;
        end
        else
        begin
            miso_oe_r <= 1'b1;
            if (sel_fall || (sclk_fall && bit_cnt_r == 3'd0))
            begin
                tx_r   <= {tx_byte[6:0], 1'b0};
                miso_r <= tx_byte[7];
            end
            else if (sclk_fall)
            begin
                tx_r   <= {tx_r[6:0], 1'b0};
                miso_r <= tx_r[7];
            end
        end
    end

    // Busy timing
    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
        begin
            ready_r    <= 1'b1;
            busy_cnt_r <= '0;
            op_done_r  <= 1'b0;
        end
        else if (op_start)
        begin
            ready_r    <= 1'b0;
            busy_cnt_r <= busy_cnt_nxt;
            op_done_r  <= 1'b0;
        end
        else if (!ready_r)
        begin
            busy_cnt_r <= busy_cnt_r - CNT_W'(1);
            if (busy_cnt_r <= CNT_W'(1))
            begin
                ready_r   <= 1'b1;
                op_done_r <= 1'b1;
            end
        end
        else
            op_done_r <= 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (in_reset)
            active_r <= 1'b0;
        else
            active_r <= selected;
    end

    assign link.miso_o  = miso_r;
    assign link.miso_oe = miso_oe_r;
    assign link.ready   = ready_r;
    assign rx_byte      = rx_byte_r;
    assign rx_valid     = rx_valid_r;
    assign rx_first     = rx_first_r;
    assign op_done      = op_done_r;
    assign frame_active = active_r;
endmodule : flash_end

// File: host_end.sv
`timescale 1ns/1ps
module host_end
#(
    parameter int unsigned POWERUP_CYC = flash_link_pkg::POWERUP_WAIT_CYC,
    parameter bit          IDLE_HIGH   = 1'b0
)
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Link
    flash_link_if.host      link,
    // User side: byte stream of one command
    input  wire logic [7:0] cmd_byte,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_last,
    output logic            cmd_ready,
    output logic [7:0]      resp_byte,
    output logic            resp_valid,
    // User side: status
    output logic            link_idle,
    output logic            dev_ready,
    input  wire logic       flash_reset_req
);
    import flash_link_pkg::*;

    typedef enum logic [2:0] {ST_POWERUP, ST_IDLE, ST_SETUP, ST_SHIFT, ST_HOLD, ST_GAP} hstate_t;

    hstate_t     state_r;
    logic [31:0] cnt_r;
    logic [2:0]  bit_r;
    logic [7:0]  out_r;
    logic [7:0]  in_r;
    logic        last_r;
    logic        sel_n_r;
    logic        sclk_r;
    logic        mosi_r;
    logic        rstn_r;
    logic        ready_r;
    logic [7:0]  resp_r;
    logic        resp_v_r;
    logic [2:0]  miso_s_r;
    logic [2:0]  rdy_s_r;

    wire cnt_zero  = cnt_r == 32'h0;
    wire half_done = cnt_r == 32'(SCK_HALF_CYC - 1);
    wire take_cmd  = state_r == ST_IDLE && cmd_valid && !flash_reset_req && rstn_r;
    wire [7:0] in_nxt = {in_r[6:0], miso_s_r[2]};

    always_ff @(posedge clk_sys)
    begin
        miso_s_r <= {miso_s_r[1:0], link.miso};
        rdy_s_r  <= {rdy_s_r[1:0], link.ready};
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            state_r  <= ST_POWERUP;
            cnt_r    <= 32'(POWERUP_CYC);
            bit_r    <= '0;
            out_r    <= 8'h00;
            in_r     <= 8'h00;
            last_r   <= 1'b0;
            sel_n_r  <= 1'b1;
            sclk_r   <= 1'b0;
            mosi_r   <= 1'b0;
            rstn_r   <= 1'b0;
            resp_r   <= 8'h00;
            resp_v_r <= 1'b0;
            ready_r  <= 1'b0;
        end
        else
        begin
            resp_v_r <= 1'b0;
            if (rdy_s_r[2] == rdy_s_r[1])
                ready_r <= rdy_s_r[1];
            // reset released only while select is high
            rstn_r <= !flash_reset_req && (rstn_r || sel_n_r);
            unique case (state_r)
                ST_POWERUP:
                begin
                    sclk_r <= IDLE_HIGH;
                    if (cnt_zero)
                        state_r <= ST_IDLE;
                    else
                        cnt_r <= cnt_r - 32'h1;
                end
                ST_IDLE:
                    if (take_cmd)
                    begin
                        sel_n_r <= 1'b0;
                        out_r   <= cmd_byte;
                        last_r  <= cmd_last;
                        mosi_r  <= cmd_byte[7];
                        bit_r   <= '0;
                        cnt_r   <= '0;
                        state_r <= ST_SETUP;
                    end
                ST_SETUP:
                begin
                    sclk_r <= 1'b0;
                    cnt_r  <= cnt_r + 32'h1;
                    if (half_done)
                    begin
                        cnt_r   <= '0;
                        state_r <= ST_SHIFT;
                    end
                end
                ST_SHIFT:
                begin
                    cnt_r <= cnt_r + 32'h1;
                    if (half_done)
                    begin
                        cnt_r <= '0;
                        // Sample at end of high phase: round trip spans both synchronisers
                        if (!sclk_r)
                            sclk_r <= 1'b1;
                        else if (bit_r != 3'(BITS_PER_BYTE - 1))
                        begin
                            sclk_r <= 1'b0;
                            in_r   <= in_nxt;
                            bit_r  <= bit_r + 3'd1;
                            out_r  <= {out_r[6:0], 1'b0};
                            mosi_r <= out_r[6];
                        end
                        else
                        begin
                            resp_r   <= in_nxt;
                            resp_v_r <= 1'b1;
                            if (last_r || !cmd_valid)
                                state_r <= ST_HOLD;
                            else
                            begin
                                sclk_r <= 1'b0;
                                bit_r  <= '0;
                                out_r  <= cmd_byte;
                                mosi_r <= cmd_byte[7];
                                last_r <= cmd_last;
                            end
                        end
                    end
                end
                ST_HOLD:
                begin
                    sclk_r <= IDLE_HIGH;
                    cnt_r  <= cnt_r + 32'h1;
                    if (half_done)
                    begin
                        sel_n_r <= 1'b1;
                        cnt_r   <= 32'(CS_HIGH_CYC);
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP:
                    if (cnt_zero)
                        state_r <= ST_IDLE;
                    else
                        cnt_r <= cnt_r - 32'h1;
            endcase
        end
    end

    wire next_take = state_r == ST_SHIFT && half_done && sclk_r
                     && bit_r == 3'(BITS_PER_BYTE - 1) && !last_r;

    assign cmd_ready    = take_cmd || next_take;
    assign link.select_n = sel_n_r;
    assign link.sclk     = sclk_r;
    assign link.mosi     = mosi_r;
    assign link.reset_n  = rstn_r;
    assign resp_byte     = resp_r;
    assign resp_valid    = resp_v_r;
    assign link_idle     = state_r == ST_IDLE;
    assign dev_ready     = ready_r;
endmodule : host_end

// File: flash_link_monitor.sv
`timescale 1ns/1ps
module flash_link_monitor
    import flash_link_pkg::*;
#(
    parameter int unsigned POWERUP_CYC  = 100,
    parameter int unsigned MAX_BUSY_CYC = 200
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // Link
    input wire logic select_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe,
    input wire logic ready,
    input wire logic reset_n
);
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    // Cycles with select high, sclk rises in a frame, busy cycles, cycles since reset
    int unsigned gap_r;
    int unsigned rise_r;
    int unsigned busy_r;
    int unsigned up_r;

    always_ff @(posedge clk_sys)
    begin
        gap_r  <= srst ? 0 : (select_n ? ((gap_r < 1000) ? gap_r + 1 : gap_r) : 0);
        rise_r <= (srst || select_n) ? 0 : rise_r + ($rose(sclk) ? 1 : 0);
        busy_r <= (srst || ready) ? 0 : ((busy_r < 100000) ? busy_r + 1 : busy_r);
        up_r   <= srst ? 0 : ((up_r <= POWERUP_CYC) ? up_r + 1 : up_r);
    end

    a_powerup_wait: assert property ($fell(select_n) |-> up_r >= POWERUP_CYC)
        else $error("frame started before power-up wait");
    a_sclk_high_phase: assert property ($rose(sclk) |-> sclk [*3])
        else $error("serial clock high phase too short");
    a_sclk_low_phase: assert property ($fell(sclk) |-> !sclk [*3])
        else $error("serial clock low phase too short");
    a_idle_clock_low: assert property (select_n |-> !sclk)
        else $error("serial clock not idle low in mode 0");
    a_mosi_setup: assert property ($rose(sclk) |-> $stable(mosi))
        else $error("serial input changed at sampling edge");
    a_byte_framing: assert property ($rose(select_n) |-> rise_r != 0 && rise_r % 8 == 0)
        else $error("frame is not whole bytes");
    a_select_gap: assert property ($fell(select_n) |-> gap_r >= CS_HIGH_CYC)
        else $error("select high time too short");
    a_busy_prompt: assert property ($fell(ready) |-> select_n && gap_r <= SELECT_TO_BUSY_CYC)
        else $error("busy not raised promptly after select release");
    a_busy_bound: assert property (!ready |-> busy_r < MAX_BUSY_CYC + 8)
        else $error("internal operation ran too long");
    a_reset_order: assert property ($rose(reset_n) |-> select_n)
        else $error("reset released while selected");
    a_output_off: assert property (select_n [*8] |-> !miso_oe && !miso_o)
        else $error("serial output driven while deselected");
endmodule : flash_link_monitor

// File: tb_serial_flash_command_timing.sv
`timescale 1ns/1ps
module tb_serial_flash_command_timing;
    import flash_link_pkg::*;
    localparam int unsigned PUP = 100;
    localparam int          LIM [5] = '{100, 200, 140, 80, 120};
    logic       clk_sys = 1'b0;
    logic       srst    = 1'b1;
    logic [7:0] cmd_byte [2], resp_byte [2], rx_byte [2], tx_byte [2], frm [4];
    logic       cmd_valid [2], cmd_last [2], cmd_ready [2], resp_valid [2], link_idle [2];
    logic       dev_ready [2], flash_reset_req [2], rx_valid [2], rx_first [2], op_done [2];
    logic       sel_n [2], sclk_w [2], mosi_w [2], ready_w [2], oe_w [2], rstn_w [2];
    logic       frame_act [2];
    op_kind_t   op_kind [2];
    logic [8:0] rx_q0 [$], rx_q1 [$];
    logic [7:0] rsp_q0 [$], rsp_q1 [$], wire_first;
    logic       sclk_q, done_seen;
    int         fails = 0, cmp_count = 0, wire_n = 0;

    always #5 clk_sys = ~clk_sys;

    for (genvar g = 0; g < 2; g++)
    begin : g_pair
        flash_link_if lnk();
        assign sel_n[g]  = lnk.select_n;
        assign sclk_w[g] = lnk.sclk;
        assign mosi_w[g] = lnk.mosi;
        assign ready_w[g] = lnk.ready;
        assign oe_w[g]   = lnk.miso_oe;
        assign rstn_w[g] = lnk.reset_n;
        host_end #(.POWERUP_CYC(PUP), .IDLE_HIGH(g == 1)) i_host_end (.clk_sys(clk_sys),
            .srst(srst), .link(lnk), .cmd_byte(cmd_byte[g]), .cmd_valid(cmd_valid[g]),
            .cmd_last(cmd_last[g]), .cmd_ready(cmd_ready[g]), .resp_byte(resp_byte[g]),
            .resp_valid(resp_valid[g]), .link_idle(link_idle[g]), .dev_ready(dev_ready[g]),
            .flash_reset_req(flash_reset_req[g]));
        flash_end #(.XFER_CYC(100), .ERASE_PROG_CYC(200), .PROG_CYC(140), .PAGE_ERASE_CYCS(80),
            .BLOCK_ERASE_CYCS(120)) i_flash_end (.clk_sys(clk_sys), .srst(srst), .link(lnk),
            .rx_byte(rx_byte[g]), .rx_valid(rx_valid[g]), .rx_first(rx_first[g]),
            .tx_byte(tx_byte[g]), .op_kind(op_kind[g]), .op_done(op_done[g]),
            .frame_active(frame_act[g]));
        if (g == 0)
        begin : g_mon
            flash_link_monitor #(.POWERUP_CYC(PUP), .MAX_BUSY_CYC(200)) i_flash_link_monitor (
                .clk_sys(clk_sys), .srst(srst), .select_n(lnk.select_n), .sclk(lnk.sclk),
                .mosi(lnk.mosi), .miso_o(lnk.miso_o), .miso_oe(lnk.miso_oe),
                .ready(lnk.ready), .reset_n(lnk.reset_n));
        end
    end

    // Collect received bytes, responses, completion and the first byte seen on the wire
    always @(posedge clk_sys)
    begin
        if (rx_valid[0] === 1'b1) rx_q0.push_back({rx_first[0], rx_byte[0]});
        if (rx_valid[1] === 1'b1) rx_q1.push_back({rx_first[1], rx_byte[1]});
        if (resp_valid[0] === 1'b1) rsp_q0.push_back(resp_byte[0]);
        if (resp_valid[1] === 1'b1) rsp_q1.push_back(resp_byte[1]);
        if (op_done[0] === 1'b1) done_seen = 1'b1;
        if (sel_n[0] !== 1'b0) wire_n = 0;
        else if (sclk_w[0] === 1'b1 && sclk_q === 1'b0)
        begin
            if (wire_n < 8) wire_first = {wire_first[6:0], mosi_w[0]};
            wire_n++;
        end
        sclk_q = sclk_w[0];
    end

    task automatic stop_test();
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic send_frame(input int p, input int n, input op_kind_t op);
        int k;
        rx_q0.delete();
        rx_q1.delete();
        rsp_q0.delete();
        rsp_q1.delete();
        @(negedge clk_sys);
        op_kind[p] = op;
        tx_byte[p] = frm[0] ^ 8'h5a;
        for (int i = 0; i < n; i++)
        begin
            @(negedge clk_sys);
            cmd_valid[p] = 1'b1;
            cmd_byte[p]  = frm[i];
            cmd_last[p]  = (i == n - 1);
            k = 0;
            do
            begin
                @(posedge clk_sys);
                k++;
            end while (cmd_ready[p] !== 1'b1 && k < 2000);
            chk(k < 2000, 1'b1, "command byte taken");
        end
        chk(frame_act[p], 1'b1, "frame active while selected");
        @(negedge clk_sys);
        cmd_valid[p] = 1'b0;
        cmd_last[p]  = 1'b0;
        k = 0;
        while ((sel_n[p] !== 1'b1 || (p ? rx_q1.size() : rx_q0.size()) < n
                || (p ? rsp_q1.size() : rsp_q0.size()) < n) && k < 3000)
        begin
            @(posedge clk_sys);
            k++;
        end
        repeat (8) @(posedge clk_sys);
        chk(p ? rx_q1.size() : rx_q0.size(), n, "received byte count");
        chk(p ? rsp_q1.size() : rsp_q0.size(), n, "response byte count");
        for (int i = 0; i < n; i++)
        begin
            chk(p ? rx_q1[i] : rx_q0[i], {i == 0, frm[i]}, "received byte");
            chk(p ? rsp_q1[i] : rsp_q0[i], tx_byte[p], "response byte");
        end
        if (p == 0) chk(wire_first, frm[0], "first byte on wire, msb first");
        chk(oe_w[p], 1'b0, "serial output released");
        chk(sclk_w[p], p == 1, "serial clock idle level");
        chk(frame_act[p], 1'b0, "frame inactive after release");
    endtask : send_frame

    task automatic wait_busy(input int lim);
        int k;
        k = 0;
        while (ready_w[0] !== 1'b0 && k < 30)
        begin
            @(posedge clk_sys);
            k++;
        end
        chk(k < 30, 1'b1, "busy raised after release");
        done_seen = 1'b0;
        k = 0;
        while (ready_w[0] !== 1'b1 && k < lim + 50)
        begin
            @(posedge clk_sys);
            k++;
        end
        chk(k <= lim + 8, 1'b1, "busy length within limit");
        repeat (5) @(posedge clk_sys);
        chk(done_seen, 1'b1, "operation end reported");
        chk(dev_ready[0], 1'b1, "host sees device ready");
    endtask : wait_busy

    initial
    begin
        #200us;
        fails++;
        stop_test();
    end

    initial
    begin
        for (int p = 0; p < 2; p++)
        begin
            cmd_byte[p] = 8'h00;
            cmd_valid[p] = 1'b0;
            cmd_last[p] = 1'b0;
            flash_reset_req[p] = 1'b0;
            op_kind[p] = OP_NONE;
        end
        tx_byte[0] = 8'hc3;
        tx_byte[1] = 8'h3c;
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        repeat (50) @(posedge clk_sys);
        chk(link_idle[0], 1'b0, "host still in power-up wait");
        chk(sel_n[0], 1'b1, "no select during power-up wait");
        // Every internal operation kind, reserved address byte kept zero
        for (int i = 0; i < 5; i++)
        begin
            frm = '{8'h80 + 8'(i), 8'h00, 8'h12, 8'h34};
            send_frame(0, 4, op_kind_t'(i + 1));
            wait_busy(LIM[i]);
        end
        // A frame with no internal operation leaves the device ready
        frm = '{8'hd7, 8'hff, 8'h00, 8'h00};
        send_frame(0, 2, OP_NONE);
        repeat (30)
        begin
            @(posedge clk_sys);
            chk(ready_w[0], 1'b1, "no busy without operation");
        end
        // Clock idling high on the second pair
        frm = '{8'h01, 8'hfe, 8'h5a, 8'h00};
        send_frame(1, 3, OP_XFER_COMPARE);
        chk(ready_w[1], 1'b0, "busy raised in mode 3");
        // Device reset driven from the host, select held high throughout
        @(negedge clk_sys);
        flash_reset_req[0] = 1'b1;
        repeat (10) @(posedge clk_sys);
        chk(rstn_w[0], 1'b0, "device reset asserted");
        chk(sel_n[0], 1'b1, "select high during reset");
        @(negedge clk_sys);
        flash_reset_req[0] = 1'b0;
        repeat (20) @(posedge clk_sys);
        chk(ready_w[0], 1'b1, "device ready after reset");
        chk(oe_w[0], 1'b0, "output off after reset");
        stop_test();
    end
endmodule : tb_serial_flash_command_timing
